// ### design/otp_pkg.sv
// shared constants and carrier types for the otp and security configuration block
package otp_pkg;

  // ****************************************************************
  // array geometry and port widths
  // ****************************************************************
  localparam int unsigned   SECTORS         = 4;
  localparam int unsigned   ROWS_PER_SECTOR = 512;
  localparam int unsigned   WORD_W          = 32;
  localparam int unsigned   ADDR_PORT_W     = 16;
  localparam int unsigned   CTRL_PORT_W     = 16;
  localparam int unsigned   REG_ADDR_W      = 8;

  // ****************************************************************
  // port resource identifiers
  // ****************************************************************
  localparam logic [31:0]   RES_ID_ADDR     = 32'h0010_0200;
  localparam logic [31:0]   RES_ID_DATA     = 32'h0020_0100;
  localparam logic [31:0]   RES_ID_CTRL     = 32'h0010_0300;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0]    OFS_ADDR        = 8'h00;
  localparam logic [7:0]    OFS_DATA        = 8'h04;
  localparam logic [7:0]    OFS_CTRL        = 8'h08;
  localparam logic [7:0]    OFS_STATUS      = 8'h0c;
  localparam logic [7:0]    OFS_SECURITY    = 8'h10;
  localparam logic [7:0]    OFS_RID_ADDR    = 8'h14;
  localparam logic [7:0]    OFS_RID_DATA    = 8'h18;
  localparam logic [7:0]    OFS_RID_CTRL    = 8'h1c;

  // ****************************************************************
  // security word fields
  // ****************************************************************
  localparam int unsigned   SEC_NO_SCAN     = 0;
  localparam int unsigned   SEC_NO_LINK     = 1;
  localparam int unsigned   SEC_SECURE_BOOT = 5;
  localparam int unsigned   SEC_REDUNDANT   = 7;
  localparam int unsigned   SEC_LOCK_LO     = 8;
  localparam int unsigned   SEC_MASTER_LOCK = 12;
  localparam int unsigned   SEC_NO_SCAN_OTP = 13;
  localparam int unsigned   SEC_GP_LO       = 15;
  localparam int unsigned   SEC_GP_HI       = 21;
  localparam int unsigned   SEC_UID_LO      = 22;
  localparam int unsigned   SEC_UID_HI      = 31;
  localparam logic [31:0]   SEC_RESET       = 32'h0000_0000;

  // ****************************************************************
  // control port commands and status bits
  // ****************************************************************
  localparam logic [1:0]    CMD_PROG_ROW    = 2'h1;
  localparam logic [1:0]    CMD_PROG_SEC    = 2'h2;
  localparam logic [1:0]    CMD_READ_ROW    = 2'h3;
  localparam int unsigned   STAT_BUSY       = 0;
  localparam int unsigned   STAT_REFUSED    = 1;
  localparam int unsigned   STAT_READY      = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned   CLK_PERIOD_NS   = 10;
  localparam int unsigned   PROG_TIME_NS    = 1000;
  localparam int unsigned   PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic scan_debug_en;
    logic link_access_en;
    logic scan_otp_en;
    logic redundancy_en;
    logic boot_from_otp;
  } sec_gates_t;

  localparam sec_gates_t    GATES_RESET     = '{default: 1'b0};

endpackage : otp_pkg

// ### design/otp_fuse_array.sv
// one-time-programmable storage rows plus the security word
module otp_fuse_array #(
  parameter int unsigned ROWS  = 2048,
  parameter int unsigned W     = 32,
  parameter int unsigned IDX_W = $clog2(ROWS)
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             row_we_i,
  input  wire logic             sec_we_i,
  input  wire logic [IDX_W-1:0] wr_idx_i,
  input  wire logic [W-1:0]     wr_data_i,
  input  wire logic [IDX_W-1:0] rd_idx_i,
  output logic      [W-1:0]     rd_data_o,
  input  wire logic [IDX_W-1:0] scan_idx_i,
  output logic      [W-1:0]     scan_data_o,
  output logic      [W-1:0]     sec_o
);

  if (ROWS < 2 || (1 << IDX_W) < ROWS) begin : g_bad_rows
    $error("otp_fuse_array: bad ROWS/IDX_W");
  end

  logic [W-1:0] mem_r [ROWS];
  logic [W-1:0] sec_r;

  // ****************************************************************
  // rows: a write can only add bits
  // ****************************************************************
  for (genvar g = 0; g < ROWS; g++) begin : g_row
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        mem_r[g] <= '0;
      end else if (row_we_i && wr_idx_i == IDX_W'(g)) begin
        mem_r[g] <= mem_r[g] | wr_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sec_r <= '0;
    end else if (sec_we_i) begin
      sec_r <= sec_r | wr_data_i;
    end
  end

  assign rd_data_o   = mem_r[rd_idx_i];
  assign scan_data_o = mem_r[scan_idx_i];
  assign sec_o       = sec_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_sec_fuse_keep: assert property (sec_we_i |=> (sec_r & $past(sec_r)) == $past(sec_r))
    else $error("security fuse bit cleared");
  chk_row_fuse_keep: assert property (row_we_i |=> (mem_r[$past(wr_idx_i)] & $past(rd_data_o)) == $past(rd_data_o)
                                      || $past(rd_idx_i) != $past(wr_idx_i))
    else $error("row fuse bit cleared");

endmodule : otp_fuse_array

// ### design/otp_security_config.sv
// otp programming ports, power-up security load, boot copy and access gating

module otp_security_config #(
  parameter int unsigned SECTORS         = otp_pkg::SECTORS,
  parameter int unsigned ROWS_PER_SECTOR = otp_pkg::ROWS_PER_SECTOR,
  parameter logic [21:0] USERCODE_LOW    = 22'h00_0001 // arbitrary value
) (
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  input  wire otp_pkg::reg_req_t reg_req_i,
  output logic        [31:0]     reg_rdata_o,
  input  wire logic              scan_otp_rd_i,
  input  wire logic   [15:0]     scan_otp_addr_i,
  output logic        [31:0]     scan_otp_rdata_o,
  output logic                   scan_otp_refused_o,
  output otp_pkg::sec_gates_t    gates_o,
  output logic        [31:0]     usercode_o,
  output logic                   sram_we_o,
  output logic        [15:0]     sram_addr_o,
  output logic        [31:0]     sram_wdata_o,
  output logic                   boot_start_o
);

  localparam int unsigned ROWS  = SECTORS * ROWS_PER_SECTOR;
  localparam int unsigned IDX_W = $clog2(ROWS);
  localparam int unsigned SEC_W = $clog2(SECTORS);

  if (SECTORS != 4 || ROWS_PER_SECTOR < 2 || (1 << IDX_W) != ROWS || IDX_W > 16) begin : g_bad_geometry
    $error("otp_security_config: unsupported geometry");
  end

  typedef enum logic [2:0] {S_LOAD, S_COPY, S_BOOT, S_IDLE, S_PROG} fsm_t;

  typedef struct packed {
    fsm_t                fsm;
    logic [IDX_W-1:0]    idx;
    logic [15:0]         addr_port;
    logic [31:0]         data_port;
    logic [15:0]         ctrl_port;
    logic [15:0]         cnt;
    logic                prog_sec;
    logic                refused;
    logic [31:0]         sec;
    logic [31:0]         rd_word;
    logic [31:0]         rdata;
    otp_pkg::sec_gates_t gates;
    logic [31:0]         usercode;
    logic                sram_we;
    logic [15:0]         sram_addr;
    logic [31:0]         sram_wdata;
    logic                boot_start;
    logic [31:0]         scan_rdata;
    logic                scan_refused;
  } state_t;

  state_t           s_r;
  state_t           s_nxt;
  logic [31:0]      arr_rd;
  logic [31:0]      arr_scan;
  logic [31:0]      arr_sec;
  logic [IDX_W-1:0] arr_rd_idx;
  logic             row_we;
  logic             sec_we;
  logic             prog_done;
  logic [1:0]       cmd;
  logic [SEC_W-1:0] sector;
  logic             addr_ok;
  logic             sec_locked;

  // ****************************************************************
  // fuse storage
  // ****************************************************************
  assign prog_done  = (s_r.fsm == S_PROG) && (s_r.cnt == 16'h0000);
  assign row_we     = prog_done && !s_r.prog_sec;
  assign sec_we     = prog_done && s_r.prog_sec;
  assign arr_rd_idx = (s_r.fsm == S_COPY) ? s_r.idx : s_r.addr_port[IDX_W-1:0];

  otp_fuse_array #(
    .ROWS  (ROWS),
    .W     (otp_pkg::WORD_W),
    .IDX_W (IDX_W)
  ) u_fuses (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .row_we_i    (row_we),
    .sec_we_i    (sec_we),
    .wr_idx_i    (s_r.addr_port[IDX_W-1:0]),
    .wr_data_i   (s_r.data_port),
    .rd_idx_i    (arr_rd_idx),
    .rd_data_o   (arr_rd),
    .scan_idx_i  (scan_otp_addr_i[IDX_W-1:0]),
    .scan_data_o (arr_scan),
    .sec_o       (arr_sec)
  );

  // ****************************************************************
  // gating derived from the security word
  // ****************************************************************
  function automatic otp_pkg::sec_gates_t gates_of(input logic [31:0] sec);
    otp_pkg::sec_gates_t g;
    g.scan_debug_en  = !sec[otp_pkg::SEC_NO_SCAN];
    g.link_access_en = !sec[otp_pkg::SEC_NO_LINK];
    g.scan_otp_en    = !sec[otp_pkg::SEC_NO_SCAN_OTP];
    g.redundancy_en  = sec[otp_pkg::SEC_REDUNDANT];
    g.boot_from_otp  = sec[otp_pkg::SEC_SECURE_BOOT];
    return g;
  endfunction : gates_of

  assign cmd        = reg_req_i.wdata[1:0];
  assign sector     = s_r.addr_port[IDX_W-1:IDX_W-SEC_W];
  assign addr_ok    = (s_r.addr_port >> IDX_W) == 16'h0000;
  assign sec_locked = s_r.sec[otp_pkg::SEC_LOCK_LO + 32'(sector)];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt              = s_r;
    s_nxt.sram_we      = 1'b0;
    s_nxt.boot_start   = 1'b0;
    s_nxt.scan_refused = 1'b0;
    case (s_r.fsm)
      S_LOAD: begin
        s_nxt.sec = arr_sec;
        s_nxt.idx = '0;
        s_nxt.fsm = S_COPY;
      end
      S_COPY: begin
        s_nxt.sram_we    = 1'b1;
        s_nxt.sram_addr  = 16'(s_r.idx);
        s_nxt.sram_wdata = arr_rd;
        if (s_r.idx == IDX_W'(ROWS - 1)) begin
          s_nxt.fsm = S_BOOT;
        end else begin
          s_nxt.idx = s_r.idx + 1'b1;
        end
      end
      S_BOOT: begin
        s_nxt.boot_start = 1'b1;
        s_nxt.fsm        = S_IDLE;
      end
      S_PROG: begin
        if (s_r.cnt == 16'h0000) begin
          if (s_r.prog_sec) begin
            s_nxt.sec = s_r.sec | s_r.data_port;
          end
          s_nxt.fsm = S_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (s_nxt.fsm != S_LOAD && s_nxt.fsm != S_COPY) begin
      s_nxt.gates    = gates_of(s_nxt.sec);
      s_nxt.usercode = {s_nxt.sec[otp_pkg::SEC_UID_HI:otp_pkg::SEC_UID_LO], USERCODE_LOW};
    end
    // scan-port otp reads
    if (scan_otp_rd_i) begin
      if (!s_r.gates.scan_otp_en || (scan_otp_addr_i >> IDX_W) != 16'h0000) begin
        s_nxt.scan_rdata   = 32'h0000_0000;
        s_nxt.scan_refused = 1'b1;
      end else begin
        s_nxt.scan_rdata = arr_scan;
      end
    end
    // register reads
    s_nxt.rdata = 32'h0000_0000;
    if (reg_req_i.rd) begin
      if (reg_req_i.addr == otp_pkg::OFS_ADDR) begin
        s_nxt.rdata = {16'h0000, s_r.addr_port};
      end else if (reg_req_i.addr == otp_pkg::OFS_DATA) begin
        s_nxt.rdata = s_r.rd_word;
      end else if (reg_req_i.addr == otp_pkg::OFS_CTRL) begin
        s_nxt.rdata = {16'h0000, s_r.ctrl_port};
      end else if (reg_req_i.addr == otp_pkg::OFS_STATUS) begin
        s_nxt.rdata[otp_pkg::STAT_BUSY]    = s_r.fsm != S_IDLE;
        s_nxt.rdata[otp_pkg::STAT_REFUSED] = s_r.refused;
        s_nxt.rdata[otp_pkg::STAT_READY]   = s_r.fsm != S_LOAD && s_r.fsm != S_COPY;
        s_nxt.refused                      = 1'b0;
      end else if (reg_req_i.addr == otp_pkg::OFS_SECURITY) begin
        s_nxt.rdata = s_r.sec;
      end else if (reg_req_i.addr == otp_pkg::OFS_RID_ADDR) begin
        s_nxt.rdata = otp_pkg::RES_ID_ADDR;
      end else if (reg_req_i.addr == otp_pkg::OFS_RID_DATA) begin
        s_nxt.rdata = otp_pkg::RES_ID_DATA;
      end else if (reg_req_i.addr == otp_pkg::OFS_RID_CTRL) begin
        s_nxt.rdata = otp_pkg::RES_ID_CTRL;
      end
    end
    // register writes
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == otp_pkg::OFS_ADDR && s_r.fsm != S_PROG) begin
        s_nxt.addr_port = reg_req_i.wdata[15:0];
      end else if (reg_req_i.addr == otp_pkg::OFS_DATA && s_r.fsm != S_PROG) begin
        s_nxt.data_port = reg_req_i.wdata;
      end else if (reg_req_i.addr == otp_pkg::OFS_CTRL) begin
        s_nxt.ctrl_port = reg_req_i.wdata[15:0];
        if (cmd != 2'h0 && s_r.fsm != S_IDLE) begin
          s_nxt.refused = 1'b1;
        end else if (cmd == otp_pkg::CMD_PROG_ROW) begin
          if (s_r.sec[otp_pkg::SEC_MASTER_LOCK] || !addr_ok || sec_locked) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.fsm      = S_PROG;
            s_nxt.prog_sec = 1'b0;
            s_nxt.cnt      = 16'(otp_pkg::PROG_CYCLES - 1);
          end
        end else if (cmd == otp_pkg::CMD_PROG_SEC) begin
          if (s_r.sec[otp_pkg::SEC_MASTER_LOCK]) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.fsm      = S_PROG;
            s_nxt.prog_sec = 1'b1;
            s_nxt.cnt      = 16'(otp_pkg::PROG_CYCLES - 1);
          end
        end else if (cmd == otp_pkg::CMD_READ_ROW) begin
          if (!addr_ok) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.rd_word = arr_rd;
          end
        end
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r       <= '0;
      s_r.fsm   <= S_LOAD;
      s_r.sec   <= otp_pkg::SEC_RESET;
      s_r.gates <= otp_pkg::GATES_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o        = s_r.rdata;
  assign scan_otp_rdata_o   = s_r.scan_rdata;
  assign scan_otp_refused_o = s_r.scan_refused;
  assign gates_o            = s_r.gates;
  assign usercode_o         = s_r.usercode;
  assign sram_we_o          = s_r.sram_we;
  assign sram_addr_o        = s_r.sram_addr;
  assign sram_wdata_o       = s_r.sram_wdata;
  assign boot_start_o       = s_r.boot_start;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  chk_scan_debug_off: assert property (s_r.fsm == S_IDLE && s_r.sec[0] |-> !gates_o.scan_debug_en)
    else $error("scan debug enabled while disabled by security word");
  chk_link_access_off: assert property (s_r.fsm == S_IDLE && s_r.sec[1] |-> !gates_o.link_access_en)
    else $error("link access enabled while disabled by security word");
  chk_boot_source: assert property (boot_start_o |-> gates_o.boot_from_otp == s_r.sec[5])
    else $error("boot source does not follow secure boot bit");
  chk_redundant_rows: assert property (s_r.fsm == S_IDLE |-> gates_o.redundancy_en == s_r.sec[7])
    else $error("redundancy enable does not follow security word");
  chk_sector_lock: assert property (s_r.fsm == S_IDLE && reg_req_i.wr && reg_req_i.addr == otp_pkg::OFS_CTRL
                                    && cmd == otp_pkg::CMD_PROG_ROW && sec_locked
                                    |=> s_r.refused && s_r.fsm == S_IDLE)
    else $error("locked sector accepted programming");
  chk_master_lock: assert property (s_r.sec[12] && s_r.fsm == S_IDLE |=> s_r.fsm != S_PROG)
    else $error("programming started under master lock");
  chk_scan_otp_deny: assert property (scan_otp_rd_i && !gates_o.scan_otp_en
                                      |=> scan_otp_refused_o && scan_otp_rdata_o == 32'h0000_0000)
    else $error("scan port read otp while denied");
  chk_usercode_field: assert property (s_r.fsm == S_IDLE |-> usercode_o[31:22] == s_r.sec[31:22])
    else $error("user code top field differs from security word");
  chk_locked_until_load: assert property (s_r.fsm == S_COPY |-> gates_o == otp_pkg::GATES_RESET)
    else $error("security gates open before load finished");
  chk_copy_then_boot: assert property (sram_we_o && sram_addr_o == 16'(ROWS - 1) |=> boot_start_o)
    else $error("boot did not follow end of copy");

  chk_sec_loaded: assert property (s_r.fsm == S_COPY |-> s_r.sec == arr_sec)
    else $error("security word not loaded");
  chk_sec_matches_fuse: assert property (s_r.fsm == S_IDLE |-> s_r.sec == arr_sec)
    else $error("security word differs from fuses");

  chk_row_in_range: assert property (row_we |-> addr_ok)
    else $error("row outside the array written");
  chk_sector_write: assert property (row_we |-> !sec_locked)
    else $error("locked sector written");
  chk_prog_lock_all: assert property (s_r.sec[otp_pkg::SEC_MASTER_LOCK] |-> !row_we && !sec_we)
    else $error("fuses written under master lock");

  chk_scan_grant: assert property (scan_otp_rd_i && gates_o.scan_otp_en
                                   && (scan_otp_addr_i >> IDX_W) == 16'h0000 |=> !scan_otp_refused_o)
    else $error("granted scan read refused");
  chk_usercode_low: assert property (s_r.fsm == S_IDLE |-> usercode_o[21:0] == USERCODE_LOW)
    else $error("user code low field wrong");

  chk_sec_readback: assert property (reg_req_i.rd && reg_req_i.addr == otp_pkg::OFS_SECURITY
                                     |=> reg_rdata_o == $past(s_r.sec))
    else $error("security word read wrong");
  chk_rid_addr: assert property (reg_req_i.rd && reg_req_i.addr == otp_pkg::OFS_RID_ADDR
                                 |=> reg_rdata_o == otp_pkg::RES_ID_ADDR)
    else $error("address port id wrong");
  chk_rid_data: assert property (reg_req_i.rd && reg_req_i.addr == otp_pkg::OFS_RID_DATA
                                 |=> reg_rdata_o == otp_pkg::RES_ID_DATA)
    else $error("data port id wrong");
  chk_rid_ctrl: assert property (reg_req_i.rd && reg_req_i.addr == otp_pkg::OFS_RID_CTRL
                                 |=> reg_rdata_o == otp_pkg::RES_ID_CTRL)
    else $error("control port id wrong");

  chk_copy_order: assert property (sram_we_o && sram_addr_o != 16'(ROWS - 1)
                                   |=> sram_we_o && sram_addr_o == $past(sram_addr_o) + 16'h0001)
    else $error("boot copy row order wrong");

  cov_boot_otp: cover property (boot_start_o && gates_o.boot_from_otp);
  cov_prog_done: cover property (row_we ##1 s_r.fsm == S_IDLE);
  cov_scan_refused: cover property (scan_otp_refused_o);
  cov_sec_prog: cover property (sec_we);
  cov_master_lock: cover property (s_r.sec[otp_pkg::SEC_MASTER_LOCK] && s_r.fsm == S_IDLE);

endmodule : otp_security_config

// ### bench/sw_master.sv
// processor software model that drives the register port of the otp block
module sw_master (
  input  wire logic               sys_clk_i,
  output otp_pkg::reg_req_t       reg_req_o,
  input  wire logic        [31:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial reg_req_o = '0;

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // one-cycle write strobe, then address and data are scrambled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    reg_req_o <= '{addr: ~a, wdata: 32'hffff_ffff, wr: 1'b0, rd: 1'b0};
    #1;
    d = reg_rdata_i;
  endtask : rd
endmodule : sw_master

// ### bench/tb_top.sv
// self-checking testbench for the otp security configuration block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [21:0] UC_LOW = 22'h2a_5a5a; // arbitrary value

  logic                sys_clk_i = 1'b0;
  logic                resetn_i  = 1'b0;
  otp_pkg::reg_req_t   reg_req;
  otp_pkg::sec_gates_t gates;
  logic [31:0]         reg_rdata, scan_rdata, usercode, sram_wdata, sv, r, d1, d2, t;
  logic [15:0]         sram_addr, row;
  logic                scan_rd   = 1'b0;
  logic [15:0]         scan_addr = 16'h0000;
  logic                scan_refused, sram_we, boot_start;
  logic                booted    = 1'b0;
  logic [31:0]         seed      = 32'd39924;
  int                  n_fail = 0, num_checks = 0, copy_n = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  otp_security_config #(.USERCODE_LOW(UC_LOW)) otp_security_config_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req), .reg_rdata_o(reg_rdata),
    .scan_otp_rd_i(scan_rd), .scan_otp_addr_i(scan_addr), .scan_otp_rdata_o(scan_rdata),
    .scan_otp_refused_o(scan_refused), .gates_o(gates), .usercode_o(usercode), .sram_we_o(sram_we),
    .sram_addr_o(sram_addr), .sram_wdata_o(sram_wdata), .boot_start_o(boot_start));

  sw_master sw_master_i (.sys_clk_i(sys_clk_i), .reg_req_o(reg_req), .reg_rdata_i(reg_rdata));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [31:0] exp_gates(input logic [31:0] s);
    return {27'h0, ~s[0], ~s[1], ~s[13], s[7], s[5]};
  endfunction : exp_gates

  task automatic rnd(output logic [31:0] v);
    seed = lfsr_next(seed);
    v = seed;
  endtask : rnd

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // program command, optional second command while busy
  task automatic prog(input logic [1:0] cmd, input logic [15:0] a, input logic [31:0] d,
                      input logic refuse, input logic twice);
    logic [31:0] st;
    sw_master_i.wr(otp_pkg::OFS_ADDR, {16'h0, a});
    sw_master_i.wr(otp_pkg::OFS_DATA, d);
    sw_master_i.wr(otp_pkg::OFS_CTRL, {30'h0, cmd});
    if (twice) sw_master_i.wr(otp_pkg::OFS_CTRL, {30'h0, cmd});
    sw_master_i.rd(otp_pkg::OFS_STATUS, st);
    chk("refused", {31'h0, refuse | twice}, {31'h0, st[otp_pkg::STAT_REFUSED]});
    chk("ready", 32'h1, {31'h0, st[otp_pkg::STAT_READY]});
    for (int i = 0; i < 300 && st[otp_pkg::STAT_BUSY] !== 1'b0; i++) sw_master_i.rd(otp_pkg::OFS_STATUS, st);
    chk("busy", 32'h0, {31'h0, st[otp_pkg::STAT_BUSY]});
  endtask : prog

  task automatic readrow(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    sw_master_i.wr(otp_pkg::OFS_ADDR, {16'h0, a});
    sw_master_i.wr(otp_pkg::OFS_CTRL, {30'h0, otp_pkg::CMD_READ_ROW});
    sw_master_i.rd(otp_pkg::OFS_DATA, v);
    chk("row", exp, v);
  endtask : readrow

  task automatic scan(input logic [15:0] a, input logic [31:0] exp, input logic refuse);
    @(posedge sys_clk_i);
    scan_rd   <= 1'b1;
    scan_addr <= a;
    @(posedge sys_clk_i);
    scan_rd   <= 1'b0;
    scan_addr <= ~a;
    #1;
    chk("scan_refused", {31'h0, refuse}, {31'h0, scan_refused});
    chk("scan_data", exp, scan_rdata);
  endtask : scan

  // ****************************************************************
  // boot copy monitor
  // ****************************************************************
  always @(posedge sys_clk_i) begin
    if (resetn_i && sram_we) begin
      chk("sram_addr", 32'(copy_n), {16'h0, sram_addr});
      chk("sram_data", 32'h0, sram_wdata);
      chk("copy_gates", (copy_n == 2047) ? exp_gates(32'h0) : 32'h0, {27'h0, gates});
      copy_n++;
    end
    if (resetn_i && boot_start) begin
      chk("copies", 32'd2048, 32'(copy_n));
      booted <= 1'b1;
    end
  end

  initial begin
    #(20000 * 10);
    n_fail++;
    wrap_up();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge sys_clk_i);
    chk("reset_gates", 32'h0, {27'h0, gates});
    resetn_i <= 1'b1;
    for (int i = 0; i < 3000 && !booted; i++) @(posedge sys_clk_i);
    chk("booted", 32'h1, {31'h0, booted});
    sv = 32'h0;
    chk("gates", exp_gates(sv), {27'h0, gates});
    chk("usercode", {10'h0, UC_LOW}, usercode);
    sw_master_i.rd(otp_pkg::OFS_RID_ADDR, t); chk("rid_addr", otp_pkg::RES_ID_ADDR, t);
    sw_master_i.rd(otp_pkg::OFS_RID_DATA, t); chk("rid_data", otp_pkg::RES_ID_DATA, t);
    sw_master_i.rd(otp_pkg::OFS_RID_CTRL, t); chk("rid_ctrl", otp_pkg::RES_ID_CTRL, t);
    sw_master_i.rd(8'h20, t); chk("unmapped", 32'h0, t);
    sw_master_i.wr(otp_pkg::OFS_SECURITY, 32'hffff_ffff);
    sw_master_i.rd(otp_pkg::OFS_SECURITY, t); chk("sec_ro", 32'h0, t);
    rnd(r); rnd(d1); rnd(d2);
    row = {5'h0, 2'h1, r[8:0]};
    prog(otp_pkg::CMD_PROG_ROW, row, d1, 1'b0, 1'b0);
    readrow(row, d1);
    prog(otp_pkg::CMD_PROG_ROW, row, d2, 1'b0, 1'b1);
    readrow(row, d1 | d2);
    scan(row, d1 | d2, 1'b0);
    scan(16'h0800, 32'h0, 1'b1);
    prog(otp_pkg::CMD_PROG_ROW, 16'h07ff, d2, 1'b0, 1'b0);
    readrow(16'h07ff, d2);
    prog(otp_pkg::CMD_PROG_ROW, 16'h0800, d1, 1'b1, 1'b0);
    rnd(r);
    sv = (r & 32'hffff_8000) | 32'h0000_01a3;
    prog(otp_pkg::CMD_PROG_SEC, 16'h0, sv, 1'b0, 1'b0);
    sw_master_i.rd(otp_pkg::OFS_SECURITY, t); chk("security", sv, t);
    chk("gates", exp_gates(sv), {27'h0, gates});
    chk("usercode", {sv[31:22], UC_LOW}, usercode);
    prog(otp_pkg::CMD_PROG_ROW, 16'h0005, d1, 1'b1, 1'b0);
    readrow(16'h0005, 32'h0);
    prog(otp_pkg::CMD_PROG_ROW, 16'h0405, d1, 1'b0, 1'b0);
    readrow(16'h0405, d1);
    for (int s = 1; s < 4; s++) begin
      prog(otp_pkg::CMD_PROG_SEC, 16'h0, 32'h100 << s, 1'b0, 1'b0);
      sv = sv | (32'h100 << s);
      prog(otp_pkg::CMD_PROG_ROW, {5'h0, 2'(s), 9'h03}, d2, 1'b1, 1'b0);
    end
    prog(otp_pkg::CMD_PROG_SEC, 16'h0, 32'h2000, 1'b0, 1'b0);
    sv = sv | 32'h2000;
    chk("gates", exp_gates(sv), {27'h0, gates});
    scan(row, 32'h0, 1'b1);
    prog(otp_pkg::CMD_PROG_SEC, 16'h0, 32'h1000, 1'b0, 1'b0);
    sv = sv | 32'h1000;
    prog(otp_pkg::CMD_PROG_SEC, 16'h0, 32'h4000, 1'b1, 1'b0);
    sw_master_i.rd(otp_pkg::OFS_SECURITY, t); chk("security", sv, t);
    wrap_up();
  end
endmodule : tb_top
